// ### scp_pkg.sv
// shared constants and types of the servo stop and power cut control
package scp_pkg;

   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_HOLD = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0c;
   localparam logic [7:0] ADDR_STATE = 8'h10;
   localparam logic [7:0] ADDR_ENC = 8'h14;
   localparam logic [7:0] ADDR_CMD = 8'h18;

   // ==========================================================
   // setting ranges and reset values
   localparam logic [1:0] SM_DB_HOLD = 2'h0;
   localparam logic [1:0] SM_DB_COAST = 2'h1;
   localparam logic [1:0] SM_COAST = 2'h2;
   localparam logic G2_ZERO = 1'h0;
   localparam logic [15:0] MAXSPD_MIN = 16'h0001;
   localparam logic [15:0] MAXSPD_MAX = 16'h0064;
   localparam logic [6:0] MAXSPD_DEF = 7'h32;
   localparam logic [15:0] HOLD_MIN = 16'h0014;
   localparam logic [15:0] HOLD_MAX = 16'h03e8;
   localparam logic [9:0] HOLD_DEF = 10'h014;
   localparam logic [15:0] SPEED_UNIT_MMS = 16'h0064;
   localparam int ENC_STEP_DEF = 256;
   localparam logic [15:0] ENC_DEF = 16'h0000;
   localparam logic [31:0] CMD_RESTART = 32'h0000_0001;

   // ==========================================================
   // time base: one hold-time unit is 1 ms
   localparam int TICK_TIME_US = 1000;
   localparam int CLK_MHZ = 50;
   localparam int TICK_CYC_DEF = TICK_TIME_US * CLK_MHZ;

   // ==========================================================
   // types
   typedef enum logic [1:0]
   {
      CM_POS = 2'h0,
      CM_SPD = 2'h1,
      CM_FORCE = 2'h2
   } scp_mode_t;

   typedef enum logic [1:0]
   {
      ST_STOP = 2'h0,
      ST_RUN = 2'h1,
      ST_ZERO = 2'h2
   } scp_st_t;

   // selector settings; this is also the low bits of the control word
   typedef struct packed {
      logic [6:0] max_speed_limit;
      logic group_two_stop_select;
      logic [1:0] stop_mode_select;
   } scp_cfg_t;

   // sticky events, same layout in status and mask
   typedef struct packed {
      logic alarm;
      logic undervolt;
      logic overspeed;
      logic cut_expired;
   } scp_ev_t;

   // pin inputs after synchronisation
   typedef struct packed {
      logic servo_on;
      logic gr1;
      logic gr2;
      logic main_ok;
      logic ctrl_ok;
      logic undervolt;
   } scp_pins_t;

endpackage

// ### scp_cut_timer.sv
// power cut hold timer: counts whole milliseconds of main supply loss
`timescale 1ns/1ps
module scp_cut_timer
   import scp_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYC_DEF
)
(
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic power_lost,
   input wire logic [9:0] hold_ms,
   output logic expired
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [15:0] presc;
      logic [9:0] ms;
      logic exp;
   } scp_tmr_t;

   localparam logic [15:0] PRESC_END = 16'(TICK_CYC - 1);

   scp_tmr_t s_ff;
   scp_tmr_t nxt_s;

   if (TICK_CYC < 2 || TICK_CYC > 65536)
   begin : g_chk
      $error("TICK_CYC out of range");
   end

   // ==========================================================
   // counting; hold_ms is read live so a new value acts at once
   always_comb
   begin
      nxt_s = s_ff;
      if (!power_lost)
      begin
         nxt_s = '0;
      end
      else
      begin
         if (s_ff.presc == PRESC_END)
         begin
            nxt_s.presc = '0;
            if (!s_ff.exp)
            begin
               nxt_s.ms = s_ff.ms + 10'h001;
            end
         end
         else
         begin
            nxt_s.presc = s_ff.presc + 16'h0001;
         end
         // expiry sticks until the supply comes back
         nxt_s.exp = s_ff.exp | (nxt_s.ms >= hold_ms); // RL6
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
      begin
         s_ff <= '0;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign expired = s_ff.exp;

endmodule

// ### scp_core.sv
// stop mode selection, power cut ride-through and speed limit with APB
//
// Overview of operation
// RL1 - servo off stops by brake-hold, brake-then-coast or coast per selector
// RL2 - group one alarm stops the motor exactly like a servo off
// RL3 - group two alarm: zero-speed stop then selector mode, or as group one
// RL4 - zero-speed stop forces the internal speed reference to zero
// RL5 - force control ignores the group two selector
// RL6 - ride through supply loss shorter than hold time, else cut power
// RL7 - motor power returns once the main supply recovers
// RL8 - servo ready drops when a supply loss exceeds the hold time; here it drops as soon as the main supply is lost
// RL9 - control supply failure means plain power down, hold time ignored
// RL10 - undervoltage during a loss overrides the hold time and stops
// RL11 - maximum speed setting 1 to 100 in 100 mm/s, default 50
// RL12 - overspeed alarm raised against the active maximum speed
// RL13 - lower maximum speed allows a higher encoder resolution limit
// RL14 - brake release output drops on any alarm or servo off
// RL15 - restart-class selectors take effect only at a restart
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
module scp_core
   import scp_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYC_DEF,
   parameter int ENC_STEP = ENC_STEP_DEF
)
(
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic SERVO_ON,
   input wire logic ALARM_GROUP_ONE,
   input wire logic ALARM_GROUP_TWO,
   input wire logic MAIN_POWER_OK,
   input wire logic CONTROL_POWER_OK,
   input wire logic UNDERVOLTAGE,
   input wire logic [1:0] CONTROL_MODE,
   input wire logic [15:0] MOTOR_SPEED,
   output logic MOTOR_POWER,
   output logic DYNAMIC_BRAKE,
   output logic ZERO_SPEED_REF,
   output logic BRAKE_RELEASE_OUT,
   output logic SERVO_READY,
   output logic OVERSPEED_ALARM,
   output logic IRQ
);

   // ==========================================================
   // state of the block
   typedef struct packed {
      scp_pins_t sy1;
      scp_pins_t sy2;
      scp_cfg_t pend;
      scp_cfg_t act;
      logic [9:0] hold;
      logic [15:0] enc;
      scp_ev_t stat;
      scp_ev_t mask;
      scp_st_t st;
      logic ovs;
      logic pwr;
      logic db;
      logic zref;
      logic brk;
      logic rdy;
      logic irq;
      logic [31:0] prdata;
      logic pslverr;
   } scp_core_t;

   localparam scp_cfg_t CFG_DEF = '{
      max_speed_limit: MAXSPD_DEF,
      group_two_stop_select: G2_ZERO,
      stop_mode_select: SM_DB_HOLD
   };

   localparam scp_core_t CORE_RST = '{
      pend: CFG_DEF,
      act: CFG_DEF,
      hold: HOLD_DEF,
      enc: ENC_DEF,
      st: ST_STOP,
      db: 1'b1, // stopped in brake-hold mode, so the brake is on
      default: '0
   };

   if (ENC_STEP < 1 || ENC_STEP * 100 > 65535)
   begin : g_chk
      $error("ENC_STEP out of range");
   end

   // ==========================================================
   // helpers
   function automatic logic [15:0] clamp16(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
      clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == ADDR_CTRL) || (a == ADDR_HOLD) ||
         (a == ADDR_STAT) || (a == ADDR_MASK) || (a == ADDR_STATE) ||
         (a == ADDR_ENC) || (a == ADDR_CMD);
   endfunction

   // encoder limit grows as the speed limit shrinks
   function automatic logic [15:0] enc_limit(input logic [6:0] spd);
      logic [15:0] span;
      span = MAXSPD_MAX + 16'h0001 - {9'h000, spd};
      enc_limit = 16'(ENC_STEP * int'(span));
   endfunction

   scp_core_t s_ff;
   scp_core_t nxt_s;
   scp_pins_t pins_in;
   scp_pins_t p;
   scp_ev_t ev;
   scp_ev_t clr;
   scp_cfg_t wcfg;
   logic cut_exp;
   logic hard_stop;
   logic alarm1;
   logic g2_as_g1;
   logic stopped;
   logic run_ok;
   logic acc;
   logic wr;
   logic restart;
   logic [15:0] spd_lim;

   assign pins_in = '{servo_on: SERVO_ON, gr1: ALARM_GROUP_ONE,
      gr2: ALARM_GROUP_TWO, main_ok: MAIN_POWER_OK,
      ctrl_ok: CONTROL_POWER_OK, undervolt: UNDERVOLTAGE};
   assign p = s_ff.sy2;

   // ==========================================================
   // supply loss timer
   scp_cut_timer #(
      .TICK_CYC(TICK_CYC)
   ) u_tmr (
      .CLK_SYS(CLK_SYS),
      .RESET_N(RESET_N),
      .power_lost(~p.main_ok),
      .hold_ms(s_ff.hold),
      .expired(cut_exp)
   );

   // ==========================================================
   // stop decisions
   always_comb
   begin
      // overspeed counts as a group one alarm
      alarm1 = p.gr1 | s_ff.ovs; // RL2
      g2_as_g1 = (CONTROL_MODE == CM_FORCE) |
         s_ff.act.group_two_stop_select; // RL3 RL5
      // hold time is void on control or undervoltage failure
      hard_stop = ~p.ctrl_ok | p.undervolt | cut_exp; // RL6 RL9 RL10
      stopped = (MOTOR_SPEED == 16'h0000);
      run_ok = p.servo_on & ~hard_stop & ~alarm1;
      spd_lim = 16'(s_ff.act.max_speed_limit * SPEED_UNIT_MMS);
      acc = PSEL & PENABLE;
      wr = acc & PWRITE & addr_ok(PADDR);
      restart = wr & (PADDR == ADDR_CMD) & |(PWDATA & CMD_RESTART);
      clr = (wr && PADDR == ADDR_STAT) ? scp_ev_t'(PWDATA[3:0]) : '0;
      wcfg = scp_cfg_t'(PWDATA[9:0]);
      ev = '{alarm: alarm1 | p.gr2, undervolt: p.undervolt,
         overspeed: s_ff.ovs, cut_expired: cut_exp};
   end

   // ==========================================================
   // next state of everything
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.sy1 = pins_in;
      nxt_s.sy2 = s_ff.sy1;
      nxt_s.ovs = MOTOR_SPEED > spd_lim; // RL12
      // stop sequencing
      case (s_ff.st)
         ST_RUN:
         begin
            if (!run_ok || (p.gr2 && g2_as_g1))
            begin
               nxt_s.st = ST_STOP; // RL1 RL2 RL5
            end
            else if (p.gr2)
            begin
               nxt_s.st = ST_ZERO; // RL3
            end
         end
         ST_ZERO:
         begin
            // decelerate on zero reference, then the selector mode
            if (!run_ok || stopped)
            begin
               nxt_s.st = ST_STOP; // RL3
            end
         end
         ST_STOP:
         begin
            if (run_ok && !p.gr2 && p.main_ok)
            begin
               nxt_s.st = ST_RUN; // RL7
            end
         end
         default:
         begin
            nxt_s.st = ST_STOP;
         end
      endcase
      // register writes; values outside the range are clamped
      if (wr && PADDR == ADDR_CTRL)
      begin
         nxt_s.pend.stop_mode_select = (wcfg.stop_mode_select > SM_COAST) ?
            SM_COAST : wcfg.stop_mode_select;
         nxt_s.pend.group_two_stop_select = wcfg.group_two_stop_select;
         nxt_s.pend.max_speed_limit = 7'(clamp16(
            {9'h000, wcfg.max_speed_limit}, MAXSPD_MIN, MAXSPD_MAX)); // RL11
      end
      if (wr && PADDR == ADDR_HOLD)
      begin
         nxt_s.hold = 10'(clamp16(PWDATA[15:0], HOLD_MIN, HOLD_MAX)); // RL6
      end
      if (wr && PADDR == ADDR_MASK)
      begin
         nxt_s.mask = scp_ev_t'(PWDATA[3:0]);
      end
      // only a restart moves pending selectors into use
      if (restart)
      begin
         nxt_s.act = s_ff.pend; // RL15
      end
      if (wr && PADDR == ADDR_ENC)
      begin
         nxt_s.enc = PWDATA[15:0];
      end
      nxt_s.enc = clamp16(nxt_s.enc, 16'h0000,
         enc_limit(nxt_s.act.max_speed_limit)); // RL13
      // a new event beats a clear in the same cycle
      nxt_s.stat = (s_ff.stat & ~clr) | ev;
      nxt_s.irq = |(nxt_s.stat & nxt_s.mask);
      // outputs follow the next state so they line up with it
      nxt_s.pwr = (nxt_s.st != ST_STOP); // RL6 RL9
      nxt_s.zref = (nxt_s.st == ST_ZERO); // RL4
      nxt_s.db = (nxt_s.st == ST_STOP) &&
         ((nxt_s.act.stop_mode_select == SM_DB_HOLD) ||
         (nxt_s.act.stop_mode_select == SM_DB_COAST && !stopped)); // RL1
      nxt_s.brk = (nxt_s.st == ST_RUN); // RL14
      nxt_s.rdy = p.main_ok & ~hard_stop & ~alarm1 & ~p.gr2; // RL8
      // read data captured in the setup cycle, answered in access
      if (PSEL && !PENABLE)
      begin
         nxt_s.pslverr = ~addr_ok(PADDR);
         case (PADDR)
            ADDR_CTRL: nxt_s.prdata = {22'h000000, s_ff.pend};
            ADDR_HOLD: nxt_s.prdata = {22'h000000, s_ff.hold};
            ADDR_STAT: nxt_s.prdata = {28'h0000000, s_ff.stat};
            ADDR_MASK: nxt_s.prdata = {28'h0000000, s_ff.mask};
            ADDR_STATE: nxt_s.prdata = {14'h0000, s_ff.act, s_ff.st,
               s_ff.ovs, s_ff.rdy, s_ff.brk, s_ff.zref, s_ff.db,
               s_ff.pwr};
            ADDR_ENC: nxt_s.prdata = {16'h0000, s_ff.enc};
            default: nxt_s.prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RESET_N)
      begin
         s_ff <= CORE_RST;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // ==========================================================
   // outputs
   assign PREADY = acc; // zero wait states
   assign PRDATA = s_ff.prdata;
   assign PSLVERR = s_ff.pslverr;
   assign MOTOR_POWER = s_ff.pwr;
   assign DYNAMIC_BRAKE = s_ff.db;
   assign ZERO_SPEED_REF = s_ff.zref;
   assign BRAKE_RELEASE_OUT = s_ff.brk;
   assign SERVO_READY = s_ff.rdy;
   assign OVERSPEED_ALARM = s_ff.ovs;
   assign IRQ = s_ff.irq;

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESET_N);

   sequence gr1_at_pin;
      ALARM_GROUP_ONE [*3];
   endsequence

   sequence gr2_zero_entry;
      s_ff.st == ST_RUN && run_ok && p.gr2 && !g2_as_g1;
   endsequence

   a_servo_off_stop: assert property (
      s_ff.st == ST_RUN && !p.servo_on |=> s_ff.st == ST_STOP) // RL1
      else $error("servo off did not stop");
   a_db_hold_mode: assert property (s_ff.st == ST_STOP &&
      s_ff.act.stop_mode_select == SM_DB_HOLD |-> DYNAMIC_BRAKE) // RL1
      else $error("brake hold missing");
   a_coast_mode: assert property (
      s_ff.act.stop_mode_select == SM_COAST |-> !DYNAMIC_BRAKE) // RL1
      else $error("brake in coast mode");
   a_gr1_stop: assert property (
      p.gr1 |=> s_ff.st == ST_STOP && !MOTOR_POWER) // RL2
      else $error("group one alarm did not stop");
   a_gr2_zero: assert property (
      gr2_zero_entry |=> s_ff.st == ST_ZERO && ZERO_SPEED_REF) // RL3 RL4
      else $error("zero speed stop missing");
   a_force_mode: assert property (s_ff.st == ST_RUN && p.gr2 &&
      CONTROL_MODE == CM_FORCE |=> s_ff.st == ST_STOP) // RL5
      else $error("force mode used group two selector");
   a_cut_ride: assert property (s_ff.st == ST_RUN && run_ok &&
      !p.gr2 && !p.main_ok |=> MOTOR_POWER) // RL6
      else $error("short supply loss cut power");
   a_cut_ready: assert property (
      cut_exp |=> !SERVO_READY && !MOTOR_POWER) // RL8
      else $error("ready kept after hold time");
   a_ctrl_fail: assert property (
      !p.ctrl_ok || p.undervolt |=> !MOTOR_POWER) // RL9 RL10
      else $error("power kept on supply failure");
   a_speed_limit: assert property ( // RL12
      MOTOR_SPEED > spd_lim |=> OVERSPEED_ALARM ##1 s_ff.stat.overspeed)
      else $error("overspeed not raised");
   a_brake_apply: assert property (
      gr1_at_pin |=> !BRAKE_RELEASE_OUT) // RL14
      else $error("brake released during alarm");
   a_restart_only: assert property (!restart |=> $stable(s_ff.act)) // RL15
      else $error("selector changed without restart");

endmodule

// ### scp_host_model.sv
// host controller model: servo-on command level with a programmable lag
`timescale 1ns/1ps
module scp_host_model
(
   input wire logic clk,
   input wire logic req_on,
   input wire logic [3:0] lag,
   output logic servo_on
);
   logic [3:0] wait_ff = 4'h0;
   initial servo_on = 1'b0;
   // =====================================================
   // command follows the request on the lag+1-th edge after it changes, so a slow host
   // leaves the old level standing a while; changes only after an edge
   always @(posedge clk)
   begin
      if (req_on == servo_on)
         wait_ff <= 4'h0;
      else if (wait_ff >= lag)
      begin
         servo_on <= req_on;
         wait_ff <= 4'h0;
      end
      else
         wait_ff <= wait_ff + 4'h1;
   end
endmodule

// ### servo_stop_and_power_cut_control_test.sv
// self-checking bench of the servo stop and power cut control
`timescale 1ns/1ps
module servo_stop_and_power_cut_control_test;
   import scp_pkg::*;
   localparam logic [31:0] MSK = 32'h0003_ffce;
   logic CLK_SYS = 1'b0;
   logic RESET_N = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA;
   logic PREADY, PSLVERR, SERVO_ON, MOTOR_POWER, DYNAMIC_BRAKE;
   logic ZERO_SPEED_REF, BRAKE_RELEASE_OUT, SERVO_READY, OVERSPEED_ALARM, IRQ;
   logic ALARM_GROUP_ONE = 1'b0, ALARM_GROUP_TWO = 1'b0, UNDERVOLTAGE = 1'b0;
   logic MAIN_POWER_OK = 1'b1, CONTROL_POWER_OK = 1'b1, req_on = 1'b0;
   logic [1:0] CONTROL_MODE = CM_POS;
   logic [15:0] MOTOR_SPEED = 16'h0000;
   logic [3:0] lag = 4'h0;
   logic [9:0] act = 10'h190;
   logic [32:0] exp_q[$], msk_q[$], cur_m;
   int err_total = 0, checks_done = 0, cycles = 0, seed = 19668;

   // =====================================================
   // clock, host model and design
   always #10 CLK_SYS = ~CLK_SYS;
   scp_host_model host (.clk(CLK_SYS), .req_on(req_on), .lag(lag),
      .servo_on(SERVO_ON));
   scp_core #(.TICK_CYC(10), .ENC_STEP(256)) dut (.CLK_SYS(CLK_SYS),
      .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .SERVO_ON(SERVO_ON),
      .ALARM_GROUP_ONE(ALARM_GROUP_ONE), .ALARM_GROUP_TWO(ALARM_GROUP_TWO),
      .MAIN_POWER_OK(MAIN_POWER_OK), .CONTROL_POWER_OK(CONTROL_POWER_OK),
      .UNDERVOLTAGE(UNDERVOLTAGE), .CONTROL_MODE(CONTROL_MODE),
      .MOTOR_SPEED(MOTOR_SPEED), .MOTOR_POWER(MOTOR_POWER),
      .DYNAMIC_BRAKE(DYNAMIC_BRAKE), .ZERO_SPEED_REF(ZERO_SPEED_REF),
      .BRAKE_RELEASE_OUT(BRAKE_RELEASE_OUT), .SERVO_READY(SERVO_READY),
      .OVERSPEED_ALARM(OVERSPEED_ALARM), .IRQ(IRQ));

   // =====================================================
   // compare and closing tasks
   task automatic cmp_word(input string nm, input logic [32:0] e,
      input logic [32:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_bit(input string nm, input logic e, input logic g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // =====================================================
   // bus tasks; one idle edge after each transfer keeps a driver
   // from assigning psel twice in one time step
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK_SYS);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      @(posedge CLK_SYS);
      while (PREADY !== 1'b1)
         @(posedge CLK_SYS);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK_SYS);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e,
      input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back({1'b1, m});
      apb(1'b0, a, 32'h0);
   endtask
   // expected state word: brake released only while running
   function automatic logic [31:0] sw(input logic [1:0] s, input logic db,
      input logic zr);
      return {14'h0, act, s, 2'b00, s == ST_RUN, zr, db, 1'b0};
   endfunction
   task automatic restart(input logic [9:0] c, input logic [9:0] ca);
      wr(ADDR_CTRL, {22'h0, c});
      rd(ADDR_CTRL, {23'h0, ca}, 32'h3ff);
      wr(ADDR_CMD, CMD_RESTART);
      act = ca;
   endtask
   task automatic go_run();
      req_on <= 1'b1;
      cyc(12 + lag);
      rd(ADDR_STATE, sw(ST_RUN, 1'b0, 1'b0), MSK);
      cmp_bit("brake_out", 1'b1, BRAKE_RELEASE_OUT);
   endtask

   // =====================================================
   // read answers are compared against the oldest note
   always @(posedge CLK_SYS)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         report_and_stop();
      end
      if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && exp_q.size() > 0)
      begin
         // mask taken first: argument evaluation order is not fixed
         cur_m = msk_q.pop_front();
         cmp_word("prdata", exp_q.pop_front() & cur_m,
            {PSLVERR, PRDATA} & cur_m);
      end
   end

   // =====================================================
   // main sequence
   initial
   begin
      cyc(20);
      RESET_N <= 1'b1;
      @(posedge CLK_SYS);
      rd(ADDR_CTRL, 32'h190, '1);
      rd(ADDR_HOLD, 32'h14, '1);
      rd(ADDR_STAT, 32'h0, '1);
      rd(ADDR_MASK, 32'h0, '1);
      rd(ADDR_ENC, 32'h0, '1);
      rd(ADDR_STATE, sw(ST_STOP, 1'b0, 1'b0), 32'h0003_ffcc);
      rd(8'h1c, 33'h1_0000_0000, '1);
      wr(ADDR_ENC, 32'hffff);
      rd(ADDR_ENC, 32'h3300, '1);
      wr(ADDR_HOLD, 32'h5);
      rd(ADDR_HOLD, 32'h14, '1);
      wr(ADDR_HOLD, 32'hffff);
      rd(ADDR_HOLD, 32'h3e8, '1);
      wr(ADDR_HOLD, 32'h14);
      // every stop mode, by servo off and by group one alarm
      for (int c = 0; c < 2; c++)
         for (int m = 0; m < 3; m++)
         begin
            lag <= (c == 1) ? 4'h4 : 4'h0;
            restart({7'h32, 1'b0, 2'(m)}, {7'h32, 1'b0, 2'(m)});
            MOTOR_SPEED <= 16'(1 + {$random(seed)} % 5000);
            go_run();
            if (c == 0)
               req_on <= 1'b0;
            else
               ALARM_GROUP_ONE <= 1'b1;
            cyc(8);
            rd(ADDR_STATE, sw(ST_STOP, m != 2, 1'b0), MSK);
            cmp_bit("dyn_brake", m != 2, DYNAMIC_BRAKE);
            cmp_bit("brake_out", 1'b0, BRAKE_RELEASE_OUT);
            MOTOR_SPEED <= 16'h0000;
            cyc(6);
            rd(ADDR_STATE, sw(ST_STOP, m == 0, 1'b0), MSK);
            cmp_bit("dyn_brake", m == 0, DYNAMIC_BRAKE);
            req_on <= 1'b0;
            ALARM_GROUP_ONE <= 1'b0;
            cyc(8);
         end
      // group two alarm by selector and control mode
      for (int k = 0; k < 4; k++)
      begin
         restart({7'h32, k == 1, 2'h0}, {7'h32, k == 1, 2'h0});
         CONTROL_MODE <= (k == 2) ? CM_FORCE : ((k == 3) ? CM_SPD : CM_POS);
         MOTOR_SPEED <= 16'h0200;
         go_run();
         ALARM_GROUP_TWO <= 1'b1;
         cyc(8);
         if (k == 0 || k == 3)
            rd(ADDR_STATE, sw(ST_ZERO, 1'b0, 1'b1), MSK);
         else
            rd(ADDR_STATE, sw(ST_STOP, 1'b1, 1'b0), MSK);
         cmp_bit("zero_ref", k == 0 || k == 3, ZERO_SPEED_REF);
         MOTOR_SPEED <= 16'h0000;
         cyc(6);
         rd(ADDR_STATE, sw(ST_STOP, 1'b1, 1'b0), MSK);
         cmp_bit("zero_ref", 1'b0, ZERO_SPEED_REF);
         ALARM_GROUP_TWO <= 1'b0;
         req_on <= 1'b0;
         CONTROL_MODE <= CM_POS;
         cyc(8);
      end
      // pending selector stays inactive until a restart
      wr(ADDR_CTRL, 32'h192);
      MOTOR_SPEED <= 16'h0300;
      go_run();
      req_on <= 1'b0;
      cyc(8);
      rd(ADDR_STATE, sw(ST_STOP, 1'b1, 1'b0), MSK);
      // supply loss: short ride-through, long cut, recovery
      restart(10'h190, 10'h190);
      go_run();
      MAIN_POWER_OK <= 1'b0;
      cyc(150);
      MAIN_POWER_OK <= 1'b1;
      cyc(6);
      rd(ADDR_STATE, sw(ST_RUN, 1'b0, 1'b0), MSK);
      cmp_bit("ready", 1'b1, SERVO_READY);
      MAIN_POWER_OK <= 1'b0;
      cyc(260);
      rd(ADDR_STATE, sw(ST_STOP, 1'b1, 1'b0), MSK);
      cmp_bit("power", 1'b0, MOTOR_POWER);
      cmp_bit("ready", 1'b0, SERVO_READY);
      rd(ADDR_STAT, 32'h1, 32'h1);
      cmp_bit("irq", 1'b0, IRQ);
      wr(ADDR_MASK, 32'h1);
      cyc(2);
      cmp_bit("irq", 1'b1, IRQ);
      MAIN_POWER_OK <= 1'b1;
      cyc(12);
      rd(ADDR_STATE, sw(ST_RUN, 1'b0, 1'b0), MSK);
      cmp_bit("power", 1'b1, MOTOR_POWER);
      wr(ADDR_STAT, 32'h1);
      cyc(2);
      cmp_bit("irq", 1'b0, IRQ);
      rd(ADDR_STAT, 32'h0, 32'h1);
      // control supply failure and undervoltage override the hold time
      for (int f = 0; f < 2; f++)
      begin
         MAIN_POWER_OK <= 1'b0;
         CONTROL_POWER_OK <= (f == 1);
         UNDERVOLTAGE <= (f == 1);
         cyc(10);
         rd(ADDR_STATE, sw(ST_STOP, 1'b1, 1'b0), MSK);
         rd(ADDR_STAT, {29'h0, f == 1, 2'h0}, 32'h4);
         MAIN_POWER_OK <= 1'b1;
         CONTROL_POWER_OK <= 1'b1;
         UNDERVOLTAGE <= 1'b0;
         cyc(6);
         wr(ADDR_STAT, 32'hf);
         go_run();
      end
      // overspeed threshold follows the active maximum speed
      MOTOR_SPEED <= 16'd5000;
      cyc(6);
      cmp_bit("overspeed", 1'b0, OVERSPEED_ALARM);
      MOTOR_SPEED <= 16'd5001;
      cyc(6);
      cmp_bit("overspeed", 1'b1, OVERSPEED_ALARM);
      rd(ADDR_STATE, sw(ST_STOP, 1'b1, 1'b0), MSK);
      MOTOR_SPEED <= 16'h0000;
      req_on <= 1'b0;
      cyc(8);
      restart(10'h000, 10'h008);
      for (int s = 0; s < 2; s++)
      begin
         MOTOR_SPEED <= (s == 0) ? 16'd101 : 16'd100;
         cyc(6);
         cmp_bit("overspeed", s == 0, OVERSPEED_ALARM);
      end
      wr(ADDR_ENC, 32'hffff);
      rd(ADDR_ENC, 32'h6400, '1);
      restart(10'h3ff, 10'h326);
      wr(ADDR_ENC, 32'hffff);
      rd(ADDR_ENC, 32'h0100, '1);
      MOTOR_SPEED <= 16'd10001;
      cyc(6);
      cmp_bit("overspeed", 1'b1, OVERSPEED_ALARM);
      cyc(4);
      report_and_stop();
   end
endmodule
